// ===== inc/rtc_irq_consts.vh
// Constants for the clock interrupt controller: register map, fields, timing.
// Assumes inclusion by the design files only; definitions only.
`ifndef RTC_IRQ_CONSTS_VH
`define RTC_IRQ_CONSTS_VH

// Printed offsets are not multiples of four: kept as indices, byte address = 4 * index
`define IDX_ALARM_DATE      17'h1fff5
`define IDX_IRQ_CTRL        17'h1fff6
`define IDX_IRQ_STATUS      17'h00000
`define IDX_IRQ_MASK        17'h00001
`define IDX_EVENT_FLAGS     17'h00002

// Interrupt control fields
`define CTRL_WDOG_EN        7
`define CTRL_ALARM_EN       6
`define CTRL_PFAIL_EN       5
`define CTRL_ACT_HIGH       3
`define CTRL_PULSE          2
`define CTRL_WRITE_MASK     8'hec
`define CTRL_RESET          8'h00

// Date alarm fields
`define DATE_MASK_BIT       7
`define DATE_RW_MASK        8'hbf
`define DATE_RESET          8'h80
`define DATE_VALUE_RESET    6'h00
`define DATE_IGNORE_RESET   1'b1

// Flag and status bit positions
`define EV_WDOG             2
`define EV_ALARM            1
`define EV_PFAIL            0

// Pulse timing at 40 MHz
`define PULSE_MS            200
`define CLK_HZ              40000000
`define PULSE_CYCLES        ((`PULSE_MS * `CLK_HZ) / 1000)

`endif

// ===== logic/irq_pulse_shaper.v
// Shapes the combined interrupt request into a timed pulse or a held level.
// Assumes one clock; the pulse length is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "rtc_irq_consts.vh"

module irq_pulse_shaper
#(
    parameter PULSE_LEN = `PULSE_CYCLES
)
(
    // Clock and reset
    input  wire clk,
    input  wire resetn,
    // Control
    input  wire pulseMode,
    input  wire trigger,
    input  wire request,
    // Result
    output reg  active
);

    reg  [23:0] count_q;

    // Pulse mode restarts the timer on each new event; level mode follows the request
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count_q <= 24'h000000;
            active  <= 1'b0;
        end
        else if (pulseMode)
        begin
            if (trigger)
            begin
                count_q <= PULSE_LEN[23:0] - 24'h000001;
                active  <= 1'b1;
            end
            else if (count_q != 24'h000000)
                count_q <= count_q - 24'h000001;
            else
                active <= 1'b0;
        end
        else
        begin
            count_q <= 24'h000000;
            active  <= request;
        end
    end

endmodule

// ===== logic/rtc_interrupt_control.v
// Interrupt routing, output pin control and date alarm register of the clock block.
// Assumes an APB master on clk; event inputs are one-cycle pulses synchronous to clk.
// Operation
// - With the watchdog enable set, a watchdog timeout sets its flag and asserts the interrupt.
// - With the watchdog enable clear, a watchdog timeout only sets its flag.
// - With the alarm enable set, an alarm match sets its flag and asserts the interrupt.
// - With the alarm enable clear, an alarm match only sets its flag.
// - With the power-fail enable set, a power-fail detection sets its flag and asserts the interrupt.
// - With the power-fail enable clear, a power-fail detection only sets its flag.
// - With the polarity bit set, the interrupt pin is driven actively high when asserted.
// - With the polarity bit clear, the pin is open drain, pulled low only when asserted.
// - Pulse mode gives a pulse of about 200 ms; level mode holds until the flags are read.
// - Control bits 4, 1 and 0 read as zero and software writes zero to them.
`timescale 1ns/1ps
`include "rtc_irq_consts.vh"

module rtc_interrupt_control
#(
    parameter PULSE_LEN = `PULSE_CYCLES
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [19:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Event sources
    input  wire        wdogTimeout,
    input  wire        alarmMatch,
    input  wire        powerFail,
    // Date alarm to the match circuit
    output reg  [5:0]  alarmDate,
    output reg         alarmDateIgnore,
    // Interrupt pin as two signals
    output reg         intOut,
    output reg         intOe,
    // Bus interrupt for software
    output reg         irq
);

    // Register state
    reg  [7:0]  ctrl_q;
    reg  [7:0]  date_q;
    reg  [2:0]  flags_q;
    reg  [2:0]  status_q;
    reg  [2:0]  mask_q;
    reg  [2:0]  irqEvt_q;
    reg  [31:0] rdata_d;
    reg         hit_d;
    // Bus decode and event routing
    wire [2:0]  events;
    wire [2:0]  enables;
    wire        access;
    wire        wrEn;
    wire        rdEn;
    wire [17:0] index;
    wire        pinActive;
    wire        intNext;
    wire        intOeNext;
    wire        irqNext;
    // Register selects and access strobes
    wire        selCtrl;
    wire        selDate;
    wire        selFlags;
    wire        selStatus;
    wire        selMask;
    wire        wrCtrl;
    wire        wrDate;
    wire        wrMask;
    wire        clrFlags;
    wire        clrStatus;
    // Sticky-bit bookkeeping
    wire [2:0]  reported;
    wire [2:0]  irqEvents;

    // Word index from the byte address; low two bits ignored
    function [17:0] word_index;
        input [19:0] addr;
        begin
            word_index = {1'b0, addr[18:2]};
        end
    endfunction

    // Register select against a printed index
    function is_reg;
        input [17:0] idx;
        input [16:0] target;
        begin
            is_reg = (idx == {1'b0, target});
        end
    endfunction

    // Sticky update: only the bits software has seen are cleared, and a new event wins
    function [2:0] sticky_next;
        input [2:0] held;
        input [2:0] seen;
        input       clear;
        input [2:0] set;
        begin
            if (clear)
                sticky_next = (held & ~seen) | set;
            else
                sticky_next = held | set;
        end
    endfunction

    assign events  = {wdogTimeout, alarmMatch, powerFail};
    assign enables = {ctrl_q[`CTRL_WDOG_EN], ctrl_q[`CTRL_ALARM_EN], ctrl_q[`CTRL_PFAIL_EN]};
    assign access  = psel && penable && pready;
    assign wrEn    = access && pwrite;
    assign rdEn    = access && !pwrite;
    assign index   = word_index(paddr);

    // One select per register, shared by the write, clear and read paths
    assign selCtrl   = is_reg(index, `IDX_IRQ_CTRL);
    assign selDate   = is_reg(index, `IDX_ALARM_DATE);
    assign selFlags  = is_reg(index, `IDX_EVENT_FLAGS);
    assign selStatus = is_reg(index, `IDX_IRQ_STATUS);
    assign selMask   = is_reg(index, `IDX_IRQ_MASK);

    // Write and read-clear strobes fire only on the completing access edge
    assign wrCtrl    = wrEn && selCtrl;
    assign wrDate    = wrEn && selDate;
    assign wrMask    = wrEn && selMask;
    assign clrFlags  = rdEn && selFlags;
    assign clrStatus = rdEn && selStatus;

    // Read data was captured a cycle before the clearing edge; an event that arrived
    // in that cycle is not in it and must survive the clear
    assign reported  = prdata[2:0];

    // Enabled events only; a disabled source sets its flag but never reaches the pin
    assign irqEvents = events & enables;

    // Zero-wait slave: ready is raised in the access phase and dropped after
    // Every access takes setup plus one access cycle; no wait state is ever added
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pready <= 1'b0;
        else
            pready <= psel && !pready;
    end

    // Control register; reserved bits never store
    // Dropping them at the write means a read can never show them
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl_q <= `CTRL_RESET;
        else if (wrCtrl)
            ctrl_q <= pwdata[7:0] & `CTRL_WRITE_MASK;
    end

    // Date alarm register; bit 6 stays zero
    // Bit 6 is dropped at the write, like the reserved control bits
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            date_q <= `DATE_RESET;
        else if (wrDate)
            date_q <= pwdata[7:0] & `DATE_RW_MASK;
    end

    // Date value and its mask go to the match circuit from flops
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            alarmDate       <= `DATE_VALUE_RESET;
            alarmDateIgnore <= `DATE_IGNORE_RESET;
        end
        else
        begin
            alarmDate       <= date_q[5:0];
            alarmDateIgnore <= date_q[`DATE_MASK_BIT];
        end
    end

    // Event flags set always, enabled or not; a read of the flags register clears what it returned
    // Trade-off: a flag raised during the read shows on the next read rather than being lost
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            flags_q <= 3'h0;
        else
            flags_q <= sticky_next(flags_q, reported, clrFlags, events);
    end

    // Interrupt-causing events: only enabled sources latch here
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            irqEvt_q <= 3'h0;
        else
            irqEvt_q <= sticky_next(irqEvt_q, reported, clrFlags, irqEvents);
    end

    // Software status mirrors events; read clears, set wins over clear
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            status_q <= 3'h0;
        else
            status_q <= sticky_next(status_q, reported, clrStatus, events);
    end

    // Mask register
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mask_q <= 3'h0;
        else if (wrMask)
            mask_q <= pwdata[2:0];
    end

    // Pulse length counter or held level
    // Each enabled event restarts the pulse, so a burst stretches it rather than stacking
    irq_pulse_shaper #(
        .PULSE_LEN (PULSE_LEN)
    ) u_shaper (
        .clk       (clk),
        .resetn    (resetn),
        .pulseMode (ctrl_q[`CTRL_PULSE]),
        .trigger   (|irqEvents),
        .request   (|irqEvt_q),
        .active    (pinActive)
    );

    // Polarity: driven high when set, open drain low otherwise
    assign intNext   = ctrl_q[`CTRL_ACT_HIGH] ? pinActive : 1'b0;
    assign intOeNext = ctrl_q[`CTRL_ACT_HIGH] ? 1'b1 : pinActive;

    // Bus interrupt: any unmasked status bit
    assign irqNext   = |(status_q & mask_q);

    // Pin and bus interrupt registered for clean outputs
    // The extra cycle keeps the pin free of glitches while the mode bits change
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            intOut <= 1'b0;
            intOe  <= 1'b0;
            irq    <= 1'b0;
        end
        else
        begin
            intOut <= intNext;
            intOe  <= intOeNext;
            irq    <= irqNext;
        end
    end

    // Read multiplexer; unmapped index reads zero with an error
    // Upper bits always read zero; only the low byte carries a register
    always @*
    begin
        rdata_d = 32'h00000000;
        hit_d   = 1'b1;
        if (selCtrl)
            rdata_d = {24'h000000, ctrl_q & `CTRL_WRITE_MASK};
        else if (selDate)
            rdata_d = {24'h000000, date_q};
        else if (selFlags)
            rdata_d = {29'h00000000, flags_q};
        else if (selStatus)
            rdata_d = {29'h00000000, status_q};
        else if (selMask)
            rdata_d = {29'h00000000, mask_q};
        else
            hit_d = 1'b0;
    end

    // Read data and error presented with ready
    // Captured in the setup cycle for a zero-wait read; the flags view is one cycle old
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (psel && !pready)
        begin
            prdata  <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= !hit_d;
        end
        else
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

endmodule

// ===== verification/rtc_irq_monitor.sv
// Port checker of the clock interrupt controller.
// Assumes the byte map and latencies of the controller.
`timescale 1ns/1ps
module rtc_irq_monitor (
    // Bus
    input logic clk,
    input logic resetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [19:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    // Events and pin
    input logic wdogTimeout,
    input logic alarmMatch,
    input logic powerFail,
    input logic [5:0] alarmDate,
    input logic alarmDateIgnore,
    input logic intOut,
    input logic intOe
);
    logic [7:0] ctl_q;
    wire asrt = ctl_q[3] ? intOut : intOe;
    wire acc = psel && penable && pready;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Control shadow, so the pin can be judged by its settings
    always @(posedge clk or negedge resetn)
        if (!resetn)
            ctl_q <= 8'h00;
        else if (acc && pwrite && paddr == 20'h7ffd8)
            ctl_q <= pwdata[7:0] & 8'hec;
    wdog_pin_a: assert property (wdogTimeout && ctl_q[7] |-> ##3 asrt)
        else $error("wdog pin");
    alarm_pin_a: assert property (alarmMatch && ctl_q[6] |-> ##3 asrt)
        else $error("alarm pin");
    pfail_pin_a: assert property (powerFail && ctl_q[5] |-> ##3 asrt)
        else $error("pfail pin");
    high_drive_a: assert property (ctl_q[3] && $past(ctl_q[3]) && $past(ctl_q[3], 2) |-> intOe)
        else $error("no drive");
    drain_low_a: assert property (!ctl_q[3] && !$past(ctl_q[3]) && !$past(ctl_q[3], 2) |-> !intOut)
        else $error("drain high");
    ctrl_read_a: assert property (acc && !pwrite && paddr == 20'h7ffd8 |-> prdata == {24'h0, ctl_q})
        else $error("ctrl read");
    date_read_a: assert property (acc && !pwrite && paddr == 20'h7ffd4
        |-> prdata == {24'h0, alarmDateIgnore, 1'b0, alarmDate}) else $error("date read");
    date_write_a: assert property (acc && pwrite && paddr == 20'h7ffd4
        |-> ##2 {alarmDateIgnore, alarmDate} == {$past(pwdata[7], 2), $past(pwdata[5:0], 2)}) else $error("date out");
endmodule
bind rtc_interrupt_control rtc_irq_monitor i_rtc_irq_monitor (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .wdogTimeout(wdogTimeout), .alarmMatch(alarmMatch), .powerFail(powerFail), .alarmDate(alarmDate),
    .alarmDateIgnore(alarmDateIgnore), .intOut(intOut), .intOe(intOe));

// ===== verification/int_pin_wire.sv
// Board wire of the interrupt pin with its pull-up.
// Assumes intOe is high while the block drives the pin.
`timescale 1ns/1ps
module int_pin_wire (
    // Pin
    input logic intOut,
    input logic intOe,
    output logic pinLevel
);
    // Undriven, the pull-up wins
    assign pinLevel = intOe ? intOut : 1'b1;
endmodule

// ===== verification/rtc_interrupt_control_tb_top.sv
// Bench: APB master, event pulses and pin checks.
// Assumes a shortened pulse and the pin wire model.
`timescale 1ns/1ps
module rtc_interrupt_control_tb_top;
    localparam int PL = 20;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [19:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, adIgn, intOut, intOe, irq, pin;
    logic [5:0] ad;
    logic [2:0] ev = 0;
    logic [7:0] dv, cw;
    logic [2:0] mv;
    logic [32:0] q[$];
    int bad_count = 0, n_tests = 0;
    rtc_interrupt_control #(.PULSE_LEN(PL)) i_rtc_interrupt_control (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wdogTimeout(ev[2]), .alarmMatch(ev[1]), .powerFail(ev[0]),
        .alarmDate(ad), .alarmDateIgnore(adIgn), .intOut(intOut), .intOe(intOe), .irq(irq));
    int_pin_wire i_int_pin_wire (.intOut(intOut), .intOe(intOe), .pinLevel(pin));
    initial forever #12.5 clk = ~clk;
    task automatic chk(input string nm, input logic [32:0] s, e);
        n_tests++;
        if (s !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One transfer; e is write data, or the expected {pslverr, prdata} of a read
    task automatic apb(input logic [19:0] a, input logic w, input logic [32:0] e);
        int k = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, e[31:0]};
        if (!w)
            q.push_back(e);
        @(posedge clk);
        penable <= 1;
        do
            @(posedge clk);
        while (!pready && ++k < 20);
        {psel, penable} <= 0;
        if (!pready)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic fire(input int b);
        @(posedge clk);
        ev[b] <= 1;
        @(posedge clk);
        ev[b] <= 0;
        repeat (3) @(posedge clk);
    endtask
    // Read results arrive in request order
    always @(posedge clk)
        if (psel && penable && pready && !pwrite)
            chk("read", {pslverr, prdata}, q.pop_front());
    initial
    begin
        dv = 8'($urandom(46189));
        repeat (5) @(posedge clk);
        resetn <= 1;
        apb(20'h7ffd8, 0, 0);
        apb(20'h7ffd4, 0, 33'h80);
        apb(20'h00100, 0, 33'h100000000);
        $display("reset done");
        apb(20'h7ffd4, 1, {25'h0, dv});
        apb(20'h7ffd4, 0, {25'h0, dv & 8'hbf});
        chk("date", {adIgn, 1'b0, ad}, dv & 8'hbf);
        $display("date done");
        // Each source, enabled or not, both pin kinds; reserved bits written zero, other mask bits random
        for (int p = 0; p < 2; p++)
            for (int b = 0; b < 3; b++)
                for (int en = 0; en < 2; en++)
                begin
                    cw = 8'((en << (5 + b)) | (p << 3));
                    apb(20'h7ffd8, 1, {25'h0, cw});
                    mv = 3'($urandom) & ~3'(1 << b) | 3'(en << b);
                    apb(20'h00004, 1, {30'h0, mv});
                    apb(20'h7ffd8, 0, {25'h0, cw});
                    fire(b);
                    chk("pin", pin, p == en);
                    chk("irq", irq, en);
                    apb(20'h00008, 0, 33'(1 << b));
                    apb(20'h00000, 0, 33'(1 << b));
                    repeat (3) @(posedge clk);
                    chk("pin off", pin, p == 0);
                    chk("irq off", irq, 0);
                end
        $display("events done");
        apb(20'h7ffd8, 1, 33'h8c);
        fire(2);
        repeat (PL - 5) @(posedge clk);
        chk("pulse on", pin, 1);
        repeat (6) @(posedge clk);
        chk("pulse off", pin, 0);
        apb(20'h00008, 0, 33'h4);
        $display("pulse done");
        report_and_stop();
    end
endmodule
